// ==== edcca_pkg.sv ====
// constants shared by the energy detect and channel assessment block
package edcca_pkg;
    // register offsets on the register access port
    localparam logic [5:0] ADDR_STATUS = 6'h01;
    localparam logic [5:0] ADDR_ED     = 6'h07;
    localparam logic [5:0] ADDR_CCA    = 6'h08;
    localparam logic [5:0] ADDR_THRES  = 6'h09;
    localparam logic [5:0] ADDR_RXSYN  = 6'h15;

    // reset values and limits
    localparam logic [7:0] ED_RST    = 8'hFF;
    localparam logic [7:0] ED_MAX    = 8'h54;
    localparam logic [1:0] MODE_RST  = 2'h1;
    localparam logic [4:0] CHAN_RST  = 5'h00;
    localparam logic [7:0] THRES_RST = 8'h77;
    localparam logic [7:0] ZERO8     = 8'h00;

    // field positions
    localparam int REQ_BIT  = 7;
    localparam int MODE_HI  = 6;
    localparam int MODE_LO  = 5;
    localparam int CHAN_HI  = 4;
    localparam int THR_HI   = 3;
    localparam int PDT_BIT  = 7;

    // radio state codes seen on the state input
    localparam logic [4:0] ST_LISTEN     = 5'h01;
    localparam logic [4:0] ST_FRAME      = 5'h02;
    localparam logic [4:0] ST_AACK_LISTEN = 5'h03;
    localparam logic [4:0] ST_AACK_FRAME = 5'h04;

    // timing at a 4 ns clock
    localparam int CLK_NS      = 4;
    localparam int PROC_NS     = 12000;
    localparam int PROC_CYC    = (PROC_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYMBOL_NS   = 16000;
    localparam int SYM_CYC_DEF = (SYMBOL_NS + CLK_NS - 1) / CLK_NS;
    localparam int LONG_SYMS   = 8;
    localparam int SHORT_SYMS  = 2;
    localparam int CNT_W       = 24;

    typedef enum logic [1:0] {
        MODE_OR  = 2'h0,
        MODE_ED  = 2'h1,
        MODE_CS  = 2'h2,
        MODE_AND = 2'h3
    } edcca_mode_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_ED   = 3'h1,
        S_CCA  = 3'h2,
        S_WAIT = 3'h3,
        S_FIN  = 3'h4
    } edcca_state_t;
endpackage

// ==== edcca_win_if.sv ====
// window start and completion signals between controller and timer
`timescale 1ns/1ps
interface edcca_win_if;
    logic                       start;
    logic [edcca_pkg::CNT_W-1:0] len;
    logic                       run;
    logic                       done;

    modport ctl (output start, output len, input run, input done);
    modport tmr (input start, input len, output run, output done);
endinterface

// ==== edcca_timer.sv ====
// measurement window countdown timer
`timescale 1ns/1ps
module edcca_timer (
    input  wire logic    clk_i,
    input  wire logic    rstn_i,
    edcca_win_if.tmr     win
);
    logic [edcca_pkg::CNT_W-1:0] cnt_q;
    logic                        done_q;

    // load on start, count down to zero
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q <= '0;
        end else if (win.start) begin
            cnt_q <= win.len;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // one-cycle pulse after the last counted cycle
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (cnt_q == {{(edcca_pkg::CNT_W-1){1'b0}}, 1'b1})
                      && !win.start;
        end
    end

    assign win.run  = (cnt_q != '0);
    assign win.done = done_q;
endmodule

// ==== edcca_judge.sv ====
// busy or idle decision from energy and carrier sense
`timescale 1ns/1ps
module edcca_judge (
    input  wire edcca_pkg::edcca_mode_t mode_i,
    input  wire logic [7:0]             ed_i,
    input  wire logic [3:0]             thres_i,
    input  wire logic                   carrier_i,
    output logic                        idle_o
);
    logic       energy_busy;
    logic       busy;
    logic [8:0] limit;

    // energy threshold compare
    // 2.07 dB per threshold step is two 1.03 dB level steps
    assign limit       = {4'h0, thres_i, 1'b0};
    assign energy_busy = {1'b0, ed_i} > limit;

    always_comb begin
        case (mode_i)
            edcca_pkg::MODE_OR:  busy = carrier_i | energy_busy;
            edcca_pkg::MODE_ED:  busy = energy_busy;
            edcca_pkg::MODE_CS:  busy = carrier_i;
            edcca_pkg::MODE_AND: busy = carrier_i & energy_busy;
            default:             busy = energy_busy;
        endcase
    end

    assign idle_o = !busy;
endmodule

// ==== edcca_top.sv ====
// energy detection and clear channel assessment control
// Behaviour
// - a finished manual energy measurement pulses the shared done event.
// - in auto-ack receive states an energy request only pulses the event.
// - energy level resets to all ones, meaning never measured.
// - stored energy results are clamped to 0 through 84.
// - a write to the energy level register in the listen or frame state starts a measurement when the sequencer is idle.
// - mode 0 OR, 1 energy, 2 carrier, 3 AND.
// - host writes the request bit in a receive state to assess.
// - request bit is write-only and clears itself when taken.
// - taking a request clears the done and idle flags.
// - completion sets the done flag and pulses the done event.
// - completion sets idle flag for idle channel, clears it for busy.
// - energy busy above base level plus 2.07 dB per threshold step.
// - listening assessment lasts eight symbols plus 12 us.
// - requests outside receive states set done and pulse, no assessment.
// - in frame, modes 0,1,3 wait for a running automatic measurement, else immediate.
// - in frame, carrier-only mode completes immediately.
// - one automatic measurement per frame, eight or two symbols.
// - carrier criterion busy on a compliant signal above base level.
// - preamble detect disable keeps receiver listening for assessments.
// - manual energy measurement runs eight symbols plus 12 us then stores result.
`timescale 1ns/1ps
module edcca_top #(
    parameter int unsigned SYM_CYC  = edcca_pkg::SYM_CYC_DEF,
    parameter int unsigned PROC_CYC = edcca_pkg::PROC_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [5:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic [4:0] radio_state_code_i,
    input  wire logic       shr_detect_i,
    input  wire logic       high_rate_i,
    input  wire logic [7:0] energy_sample_i,
    input  wire logic       carrier_detect_i,
    output logic            measure_complete_event_o,
    output logic            preamble_detect_disable_o
);
    localparam logic [edcca_pkg::CNT_W-1:0] LONG_LEN =
        edcca_pkg::CNT_W'(edcca_pkg::LONG_SYMS * SYM_CYC);
    localparam logic [edcca_pkg::CNT_W-1:0] SHORT_LEN =
        edcca_pkg::CNT_W'(edcca_pkg::SHORT_SYMS * SYM_CYC);
    localparam logic [edcca_pkg::CNT_W-1:0] MAN_LEN =
        edcca_pkg::CNT_W'(edcca_pkg::LONG_SYMS * SYM_CYC + PROC_CYC);

    edcca_pkg::edcca_state_t state_q;
    edcca_pkg::edcca_mode_t  mode_q;
    logic [7:0] energy_result_field_q;
    logic [4:0] channel_q;
    logic [7:0] thres_q;
    logic       pdt_q;
    logic       done_q;
    logic       idle_q;
    logic       event_q;
    logic       is_cca_q;
    logic       skip_q;
    logic       src_auto_q;
    logic       frame_seen_q;
    logic [7:0] peak_q;
    logic       carrier_q;
    logic [7:0] rdata_q;

    logic       ed_wr;
    logic       cca_req;
    logic       in_listen;
    logic       in_frame;
    logic       in_aack;
    logic       auto_start;
    logic       man_start;
    logic       any_start;
    logic       any_run;
    logic [7:0] meas_ed;
    logic [7:0] judge_ed;
    logic       judge_idle;

    edcca_win_if man_win ();
    edcca_win_if auto_win ();

    edcca_timer u_man_timer (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .win    (man_win.tmr)
    );

    edcca_timer u_auto_timer (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .win    (auto_win.tmr)
    );

    edcca_judge u_judge (
        .mode_i    (mode_q),
        .ed_i      (judge_ed),
        .thres_i   (thres_q[edcca_pkg::THR_HI:0]),
        .carrier_i (carrier_q | carrier_detect_i),
        .idle_o    (judge_idle)
    );

    // request decode and radio state decode
    // a write to level starts in the listen or frame state when the sequencer is idle
    assign ed_wr     = reg_wr_i && (reg_addr_i == edcca_pkg::ADDR_ED);
    assign cca_req   = reg_wr_i && (reg_addr_i == edcca_pkg::ADDR_CCA)
                       && reg_wdata_i[edcca_pkg::REQ_BIT];
    assign in_listen = (radio_state_code_i == edcca_pkg::ST_LISTEN);
    assign in_frame  = (radio_state_code_i == edcca_pkg::ST_FRAME);
    assign in_aack   = (radio_state_code_i == edcca_pkg::ST_AACK_LISTEN)
                    || (radio_state_code_i == edcca_pkg::ST_AACK_FRAME);

    // manual window starts for energy or listening assessment
    assign man_start = (state_q == edcca_pkg::S_IDLE) && !cca_req && ed_wr
                       && (in_listen || in_frame) && !in_aack
                    || (state_q == edcca_pkg::S_IDLE) && cca_req
                       && in_listen;
    assign auto_start = shr_detect_i && !frame_seen_q && !pdt_q;
    assign any_start  = man_start || auto_start;
    assign any_run    = man_win.run || auto_win.run;

    assign man_win.start  = man_start;
    assign man_win.len    = MAN_LEN;
    assign auto_win.start = auto_start;
    // short window in high rate modes
    assign auto_win.len   = high_rate_i ? SHORT_LEN : LONG_LEN;

    assign meas_ed  = (peak_q > edcca_pkg::ED_MAX) ? edcca_pkg::ED_MAX
                                                    : peak_q;
    assign judge_ed = src_auto_q ? energy_result_field_q : meas_ed;

    // peak energy and carrier seen over the running window
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            peak_q    <= edcca_pkg::ZERO8;
            carrier_q <= 1'b0;
        end else if (any_start) begin
            peak_q    <= energy_sample_i;
            carrier_q <= carrier_detect_i;
        end else if (any_run) begin
            if (energy_sample_i > peak_q) begin
                peak_q <= energy_sample_i;
            end
            carrier_q <= carrier_q | carrier_detect_i;
        end
    end

    // once-per-frame marker, cleared back in the listening or auto-ack listening state
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            frame_seen_q <= 1'b0;
        end else if (auto_start) begin
            frame_seen_q <= 1'b1;
        end else if (in_listen || in_aack && !in_frame
                     && radio_state_code_i != edcca_pkg::ST_AACK_FRAME) begin
            frame_seen_q <= 1'b0;
        end
    end

    // configuration registers written by the host
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_q    <= edcca_pkg::edcca_mode_t'(edcca_pkg::MODE_RST);
            channel_q <= edcca_pkg::CHAN_RST;
            thres_q   <= edcca_pkg::THRES_RST;
            pdt_q     <= 1'b0;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                edcca_pkg::ADDR_CCA: begin
                    mode_q <= edcca_pkg::edcca_mode_t'(
                        reg_wdata_i[edcca_pkg::MODE_HI:edcca_pkg::MODE_LO]);
                    channel_q <= reg_wdata_i[edcca_pkg::CHAN_HI:0];
                end
                edcca_pkg::ADDR_THRES: thres_q <= reg_wdata_i;
                edcca_pkg::ADDR_RXSYN: pdt_q <= reg_wdata_i[edcca_pkg::PDT_BIT];
                default: ;
            endcase
        end
    end

    // level resets to all ones
    // automatic and manual results land in the level register
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            energy_result_field_q <= edcca_pkg::ED_RST;
        end else if (auto_win.done) begin
            energy_result_field_q <= meas_ed;
        end else if (state_q == edcca_pkg::S_ED && man_win.done) begin
            energy_result_field_q <= meas_ed;
        end
    end

    // measurement sequencer
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q    <= edcca_pkg::S_IDLE;
            is_cca_q   <= 1'b0;
            skip_q     <= 1'b0;
            src_auto_q <= 1'b0;
        end else begin
            case (state_q)
                edcca_pkg::S_IDLE: begin
                    if (cca_req) begin
                        is_cca_q   <= 1'b1;
                        src_auto_q <= in_frame;
                        skip_q     <= !(in_listen || in_frame);
                        if (in_listen) begin
                            state_q <= edcca_pkg::S_CCA;
                        end else if (in_frame && auto_win.run
                                     && reg_wdata_i[edcca_pkg::MODE_HI:
                                        edcca_pkg::MODE_LO]
                                        != edcca_pkg::MODE_CS) begin
                            // mode written with the request decides
                            // wait for automatic window
                            state_q <= edcca_pkg::S_WAIT;
                        end else begin
                            state_q <= edcca_pkg::S_FIN;
                        end
                    end else if (ed_wr) begin
                        is_cca_q <= 1'b0;
                        if (man_start) begin
                            state_q <= edcca_pkg::S_ED;
                        end else begin
                            state_q <= edcca_pkg::S_FIN;
                        end
                    end
                end
                edcca_pkg::S_ED: begin
                    if (man_win.done) begin
                        state_q <= edcca_pkg::S_IDLE;
                    end
                end
                edcca_pkg::S_CCA: begin
                    if (man_win.done) begin
                        state_q <= edcca_pkg::S_IDLE;
                    end
                end
                edcca_pkg::S_WAIT: begin
                    if (auto_win.done) begin
                        state_q <= edcca_pkg::S_FIN;
                    end
                end
                edcca_pkg::S_FIN: state_q <= edcca_pkg::S_IDLE;
                default: state_q <= edcca_pkg::S_IDLE;
            endcase
        end
    end

    // done and idle flags; setting and clearing never share a cycle
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            done_q <= 1'b0;
            idle_q <= 1'b0;
        end else if (state_q == edcca_pkg::S_CCA && man_win.done
                     || state_q == edcca_pkg::S_FIN && is_cca_q) begin
            done_q <= 1'b1;
            idle_q <= !skip_q && judge_idle;
        end else if (state_q == edcca_pkg::S_IDLE && cca_req) begin
            done_q <= 1'b0;
            idle_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            event_q <= 1'b0;
        end else begin
            event_q <= (state_q == edcca_pkg::S_FIN)
                    || (state_q == edcca_pkg::S_ED && man_win.done)
                    || (state_q == edcca_pkg::S_CCA && man_win.done);
        end
    end

    // registered read data; unmapped offsets read zero
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_q <= edcca_pkg::ZERO8;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                edcca_pkg::ADDR_STATUS:
                    rdata_q <= {done_q, idle_q, 1'b0, radio_state_code_i};
                edcca_pkg::ADDR_ED: rdata_q <= energy_result_field_q;
                edcca_pkg::ADDR_CCA: rdata_q <= {1'b0, mode_q, channel_q};
                edcca_pkg::ADDR_THRES: rdata_q <= thres_q;
                edcca_pkg::ADDR_RXSYN: rdata_q <= {pdt_q, 7'h00};
                default: rdata_q <= edcca_pkg::ZERO8;
            endcase
        end
    end

    assign reg_rdata_o               = rdata_q;
    assign measure_complete_event_o  = event_q;
    assign preamble_detect_disable_o = pdt_q;
endmodule

// ==== edcca_checker.sv ====
// assertion checker bound to the energy detect and assessment top
`timescale 1ns/1ps
module edcca_checker #(
    parameter int unsigned SYM_CYC  = 4,
    parameter int unsigned PROC_CYC = 3
) (
    input wire logic       clk_i,
    input wire logic       rstn_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [5:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [4:0] radio_state_code_i,
    input wire logic       shr_detect_i,
    input wire logic       high_rate_i,
    input wire logic [7:0] energy_sample_i,
    input wire logic       carrier_detect_i,
    input wire logic       measure_complete_event_o,
    input wire logic       preamble_detect_disable_o
);
    localparam int LAT = 8 * SYM_CYC + PROC_CYC + 2;
    logic        busy_q;
    logic        long_q;
    logic        short_q;
    logic [15:0] cnt_q;
    logic [1:0]  mode_q;
    logic        pdt_q;
    logic        ev;
    logic        wr_ed;
    logic        wr_req;
    logic        wr_pdt;
    logic        rx;
    logic        rd_cca;
    logic        take;
    logic        cca_q;

    // request decode
    assign ev     = measure_complete_event_o;
    assign wr_ed  = reg_wr_i && reg_addr_i == edcca_pkg::ADDR_ED;
    assign wr_req = reg_wr_i && reg_addr_i == edcca_pkg::ADDR_CCA
                    && reg_wdata_i[7];
    assign wr_pdt = reg_wr_i && reg_addr_i == edcca_pkg::ADDR_RXSYN;
    assign rd_cca = reg_rd_i && reg_addr_i == edcca_pkg::ADDR_CCA;
    assign rx     = radio_state_code_i inside {edcca_pkg::ST_LISTEN,
                                               edcca_pkg::ST_FRAME};
    assign take   = (wr_ed || wr_req) && (!busy_q || ev);

    // kind of the accepted request and cycles since it was taken
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_q  <= 1'b0;
            long_q  <= 1'b0;
            short_q <= 1'b0;
            cnt_q   <= 16'h0000;
            cca_q   <= 1'b0;
        end else if (take) begin
            busy_q  <= 1'b1;
            cca_q   <= wr_req;
            cnt_q   <= 16'h0001;
            long_q  <= wr_ed ? rx
                       : radio_state_code_i == edcca_pkg::ST_LISTEN;
            short_q <= !rx || (!wr_ed && reg_wdata_i[6:5] == 2'h2
                       && radio_state_code_i == edcca_pkg::ST_FRAME);
        end else if (ev) begin
            busy_q <= 1'b0;
        end else if (busy_q) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // mirror of the mode field and the detect disable bit
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_q <= edcca_pkg::MODE_RST;
            pdt_q  <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == edcca_pkg::ADDR_CCA) begin
            mode_q <= reg_wdata_i[6:5];
        end else if (wr_pdt) begin
            pdt_q <= reg_wdata_i[7];
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    long_time_a: assert property (busy_q && long_q |->
        ev == (cnt_q == LAT)) else $error("long request timing wrong");
    short_time_a: assert property (busy_q && short_q &&
        cnt_q == 16'h0002 |-> ev) else $error("short request late");
    no_stray_a: assert property (ev |-> busy_q && cnt_q <= LAT)
        else $error("done event without request");
    one_pulse_a: assert property (ev |=> !ev)
        else $error("done event too long");
    ed_range_a: assert property (reg_rd_i &&
        reg_addr_i == edcca_pkg::ADDR_ED |=> reg_rdata_o <= edcca_pkg::ED_MAX
        || reg_rdata_o == edcca_pkg::ED_RST) else $error("energy out of range");
    status_code_a: assert property (reg_rd_i &&
        reg_addr_i == edcca_pkg::ADDR_STATUS |=> reg_rdata_o[5:0] ==
        {1'b0, $past(radio_state_code_i)}) else $error("status code wrong");
    flags_clear_a: assert property (busy_q && cca_q && !ev && reg_rd_i &&
        reg_addr_i == edcca_pkg::ADDR_STATUS |=> reg_rdata_o[7:6] == 2'h0)
        else $error("flags not cleared");
    mode_read_a: assert property (rd_cca |=>
        reg_rdata_o[7:5] == {1'b0, mode_q}) else $error("control readback");
    pdt_copy_a: assert property (wr_pdt ##1 (!wr_pdt)[*2] |->
        preamble_detect_disable_o == pdt_q) else $error("disable pin wrong");

    cover property (take && wr_ed && rx);
    cover property (take && wr_req && radio_state_code_i == edcca_pkg::ST_FRAME);
    cover property (ev && short_q);
endmodule

bind edcca_top edcca_checker #(.SYM_CYC(SYM_CYC), .PROC_CYC(PROC_CYC))
    edcca_checker_inst (.clk_i(clk_i), .rstn_i(rstn_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .radio_state_code_i(radio_state_code_i), .shr_detect_i(shr_detect_i),
    .high_rate_i(high_rate_i), .energy_sample_i(energy_sample_i),
    .carrier_detect_i(carrier_detect_i),
    .measure_complete_event_o(measure_complete_event_o),
    .preamble_detect_disable_o(preamble_detect_disable_o));

// ==== edcca_host_model.sv ====
// host software model issuing register accesses
`timescale 1ns/1ps
module edcca_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] reg_rdata_i,
    output logic            reg_wr_o = 1'b0,
    output logic            reg_rd_o = 1'b0,
    output logic      [5:0] reg_addr_o = 6'h00,
    output logic      [7:0] reg_wdata_o = 8'h00
);
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        reg_wr_o = 1'b1;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(posedge clk_i);
        #1;
        reg_wr_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask

    // read strobe, data taken the cycle after
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        reg_rd_o = 1'b1;
        reg_addr_o = a;
        @(posedge clk_i);
        #1;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        d = reg_rdata_i;
    endtask
endmodule

// ==== tb.sv ====
// self-checking bench for the energy detect and assessment block
`timescale 1ns/1ps
module tb;
    localparam int SYM = 4;
    localparam int LAT = 8 * SYM + 3 + 2;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [4:0] st = edcca_pkg::ST_LISTEN;
    logic       shr = 1'b0;
    logic       hr = 1'b0;
    logic [7:0] smp = 8'h00;
    logic       cs = 1'b0;
    logic       ev;
    logic       pdt;
    logic [7:0] d;
    logic [7:0] e8;
    int         errors = 0;
    int         n_checks = 0;
    int         cyc = 0;
    int         wcyc;
    int         l;
    int         lvl;
    int         thr;
    int         exp_ed;
    int         ev_q[$];

    always #2 clk = ~clk;

    // cycle count and event times
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (ev === 1'b1) ev_q.push_back(cyc);
    end

    edcca_top #(.SYM_CYC(SYM), .PROC_CYC(3)) edcca_top_inst (
        .clk_i(clk), .rstn_i(rstn), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .radio_state_code_i(st), .shr_detect_i(shr), .high_rate_i(hr),
        .energy_sample_i(smp), .carrier_detect_i(cs),
        .measure_complete_event_o(ev), .preamble_detect_disable_o(pdt));
    edcca_host_model edcca_host_model_inst (
        .clk_i(clk), .reg_rdata_i(rdata), .reg_wr_o(wr), .reg_rd_o(rd),
        .reg_addr_o(addr), .reg_wdata_o(wdata));

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (e !== g) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic wrt(logic [5:0] a, logic [7:0] v);
        edcca_host_model_inst.wr(a, v);
        wcyc = cyc - 1;
    endtask
    task automatic rdc(logic [5:0] a, logic [7:0] e, string nm);
        edcca_host_model_inst.rd(a, d);
        chk(nm, e, d);
    endtask
    // latency from the taking edge to the done event, bounded
    task automatic wev;
        int n;
        n = 0;
        while (ev_q.size() == 0 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        l = ev_q.size() > 0 ? ev_q.pop_front() - wcyc : -1;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic pulse;
        shr = 1'b1;
        @(posedge clk);
        #1;
        shr = 1'b0;
    endtask
    task automatic frame_start;
        st = edcca_pkg::ST_LISTEN;
        @(posedge clk);
        #1;
        st = edcca_pkg::ST_FRAME;
        pulse;
    endtask
    function automatic int clamp(int v);
        return v > 84 ? 84 : v;
    endfunction
    function automatic logic idle_of(int m, int e, logic c);
        logic b;
        b = e > 2 * thr;
        case (m)
            0: return !(b || c);
            1: return !b;
            2: return !c;
            default: return !(b && c);
        endcase
    endfunction
    task end_of_test;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // hang guard, far beyond the expected run
    initial begin
        #80000;
        errors++;
        end_of_test;
    end

    initial begin
        void'($urandom(10));
        repeat (20) @(posedge clk);
        #1;
        rstn = 1'b1;
        rdc(edcca_pkg::ADDR_ED, 8'hFF, "ed_reset");
        rdc(edcca_pkg::ADDR_CCA, 8'h20, "cca_reset");
        rdc(edcca_pkg::ADDR_THRES, 8'h77, "thres_reset");
        rdc(edcca_pkg::ADDR_STATUS, 8'h01, "status_reset");
        rdc(edcca_pkg::ADDR_RXSYN, 8'h00, "rxsyn_reset");
        rdc(6'h3F, 8'h00, "unmapped");
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            lvl = i == 0 ? 255 : $urandom_range(255);
            smp = lvl[7:0];
            st = edcca_pkg::ST_LISTEN + 5'(i);
            wrt(edcca_pkg::ADDR_ED, 8'($urandom()));
            wev;
            if (i < 2) exp_ed = clamp(lvl);
            chk("ed_latency", i < 2 ? LAT : 2, l);
            rdc(edcca_pkg::ADDR_ED, 8'(exp_ed), "energy_result_field");
        end
        $display("test manual energy done");
        for (int m = 0; m < 4; m++) begin
            lvl = $urandom_range(40);
            thr = $urandom_range(15);
            cs = 1'($urandom_range(1));
            smp = lvl[7:0];
            st = edcca_pkg::ST_LISTEN;
            wrt(edcca_pkg::ADDR_THRES, 8'(thr));
            wrt(edcca_pkg::ADDR_CCA, {1'b1, 2'(m), 5'h00});
            rdc(edcca_pkg::ADDR_STATUS, 8'h01, "flags_cleared");
            wev;
            chk("cca_latency", LAT, l);
            e8 = {1'b1, idle_of(m, lvl, cs), 6'h01};
            rdc(edcca_pkg::ADDR_STATUS, e8, "cca_result");
            rdc(edcca_pkg::ADDR_CCA, {1'b0, 2'(m), 5'h00}, "req_clear");
        end
        $display("test listening assessment done");
        for (int s = 0; s < 2; s++) begin
            st = s == 0 ? 5'h08 : edcca_pkg::ST_AACK_LISTEN;
            wrt(edcca_pkg::ADDR_CCA, 8'hA0);
            wev;
            chk("skip_latency", 2, l);
            rdc(edcca_pkg::ADDR_STATUS, {3'h4, st}, "skip_flags");
        end
        $display("test outside receive done");
        for (int h = 0; h < 2; h++) begin
            hr = 1'(h);
            cs = 1'b0;
            lvl = $urandom_range(255);
            smp = lvl[7:0];
            frame_start;
            wrt(edcca_pkg::ADDR_CCA, 8'hA0);
            wev;
            chk("in_window", 1, l > 2 && l <= (h ? 2 : 8) * SYM + 3);
            e8 = {1'b1, idle_of(1, clamp(lvl), 1'b0), 6'h02};
            rdc(edcca_pkg::ADDR_STATUS, e8, "frame_result");
            rdc(edcca_pkg::ADDR_ED, 8'(clamp(lvl)), "auto_level");
            pulse;
            wrt(edcca_pkg::ADDR_CCA, 8'hA0);
            wev;
            chk("after_window", 2, l);
        end
        hr = 1'b0;
        cs = 1'b1;
        frame_start;
        wrt(edcca_pkg::ADDR_CCA, 8'hC0);
        wev;
        chk("cs_latency", 2, l);
        rdc(edcca_pkg::ADDR_STATUS, 8'h82, "cs_busy");
        $display("test frame assessment done");
        st = edcca_pkg::ST_LISTEN;
        wrt(edcca_pkg::ADDR_RXSYN, 8'h80);
        rdc(edcca_pkg::ADDR_RXSYN, 8'h80, "pdt_read");
        chk("pdt_pin", 1, pdt);
        wrt(edcca_pkg::ADDR_CCA, 8'hA0);
        wev;
        chk("pdt_latency", LAT, l);
        wrt(edcca_pkg::ADDR_RXSYN, 8'h00);
        rdc(edcca_pkg::ADDR_RXSYN, 8'h00, "pdt_clear");
        $display("test detect disable done");
        end_of_test;
    end
endmodule
